// *** shared/sasi_pkg.sv ***
// Shared constants and types for the SASI target port and its host adapter end
package sasi_pkg;
   localparam int SASI_DW = 8;
   localparam int SASI_ADDR_W = 3;
   // Default strap: bus address 0
   localparam logic [2:0] SASI_DEFAULT_ADDR = 3'h0;
   // Phase line levels: direction and command/data
   localparam logic SASI_IO_TO_HOST = 1'b0;
   localparam logic SASI_IO_TO_DEV = 1'b1;
   localparam logic SASI_CD_COMMAND = 1'b0;
   localparam logic SASI_CD_DATA = 1'b1;
   // Active-low line levels
   localparam logic SASI_ACTIVE_N = 1'b0;
   localparam logic SASI_INACTIVE_N = 1'b1;
   // Command length and completion message byte
   localparam logic [3:0] SASI_CMD_BYTES = 4'h6;
   localparam logic [7:0] SASI_MSG_DONE = 8'h00;
   // Sector sizes selected by the sector size strap
   localparam logic [9:0] SASI_SECT_SMALL = 10'h100;
   localparam logic [9:0] SASI_SECT_LARGE = 10'h200;
   localparam logic [5:0] SASI_SPT_SMALL = 6'h20;
   localparam logic [5:0] SASI_SPT_LARGE = 6'h11;
   // Target phases
   typedef enum logic [2:0] {
      SASI_IDLE = 3'b000,
      SASI_CMD = 3'b001,
      SASI_DIN = 3'b010,
      SASI_DOUT = 3'b011,
      SASI_STAT = 3'b100,
      SASI_MSG = 3'b101,
      SASI_REL = 3'b110
   } sasi_phase_t;
   // Handshake stage within a byte
   typedef enum logic [1:0] {
      SASI_HS_SET = 2'b00,
      SASI_HS_WAIT = 2'b01,
      SASI_HS_DROP = 2'b10
   } sasi_hs_t;
endpackage

// *** shared/sasi_if.sv ***
// SASI bus wires shared by the target and the host adapter
`timescale 1ns/10ps
`default_nettype none
interface sasi_if;
   // Data bus, one enable per end, low while driving
   logic [7:0] tgt_db_n;
   logic tgt_db_oe_n;
   logic [7:0] host_db_n;
   logic host_db_oe_n;
   logic bsy_n;
   logic req_n;
   logic io_n;
   logic cd_n;
   logic msg_n;
   logic sel_n;
   logic ack_n;
   logic rst_n;
   // Resolved active-low bus: undriven lines float high
   logic [7:0] db_n;
   assign db_n = (!tgt_db_oe_n) ? tgt_db_n : ((!host_db_oe_n) ? host_db_n : 8'hFF);
   modport target (
      input db_n, sel_n, ack_n, rst_n,
      output tgt_db_n, tgt_db_oe_n, bsy_n, req_n, io_n, cd_n, msg_n
   );
   modport host (
      input db_n, bsy_n, req_n, io_n, cd_n, msg_n,
      output host_db_n, host_db_oe_n, sel_n, ack_n, rst_n
   );
endinterface
`default_nettype wire

// *** hdl/sasi_target.sv ***
// SASI target port: selection, phase sequencing and byte handshake
`timescale 1ns/10ps
`default_nettype none
module sasi_target
   import sasi_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Bus
   sasi_if.target bus,
   // Straps
   input wire logic [2:0] addr_strap_in,
   input wire logic sector_size_strap_in,
   // Command byte stream toward the controller core
   output logic [7:0] cmd_byte_out,
   output logic cmd_valid_out,
   output logic cmd_done_out,
   // Phase choice from the core after the command
   input wire logic dir_to_host_in,
   input wire logic has_data_in,
   input wire logic [9:0] data_len_in,
   // Data bytes both ways
   input wire logic [7:0] tx_byte_in,
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out,
   output logic tx_take_out,
   // Status byte from the core
   input wire logic [7:0] status_in,
   // Sector format and busy flag
   output logic [9:0] sector_bytes_out,
   output logic [5:0] sectors_per_track_out,
   output logic busy_out
);
   sasi_phase_t phase;
   sasi_phase_t next_phase;
   sasi_hs_t hs;
   logic [7:0] db_s1, db_s2;
   logic [3:0] ctl_s1, ctl_s2;
   logic [2:0] addr;
   logic sector_large;
   logic [3:0] strap_s1;
   logic [9:0] count;
   logic bus_rst;
   logic sel_act, ack_act;
   logic drv;
   logic [7:0] out_byte;
   logic byte_done;

   // Idle and release both keep the bus lines quiet
   function automatic logic bus_quiet(input sasi_phase_t ph);
      return (ph == SASI_IDLE) || (ph == SASI_REL);
   endfunction

   // Pins come from outside the clock domain
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         db_s1 <= 8'hFF;
         db_s2 <= 8'hFF;
         ctl_s1 <= 4'hF;
         ctl_s2 <= 4'hF;
      end else begin
         db_s1 <= bus.db_n;
         db_s2 <= db_s1;
         ctl_s1 <= {bus.rst_n, bus.sel_n, bus.ack_n, 1'b1};
         ctl_s2 <= ctl_s1;
      end
   end
   assign bus_rst = (ctl_s2[3] == SASI_ACTIVE_N);
   assign sel_act = (ctl_s2[2] == SASI_ACTIVE_N);
   assign ack_act = (ctl_s2[1] == SASI_ACTIVE_N);

   // Straps are pins: first sync flop here, second is the idle capture
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         strap_s1 <= {1'b0, SASI_DEFAULT_ADDR};
      end else begin
         strap_s1 <= {sector_size_strap_in, addr_strap_in};
      end
   end

   // Straps caught only while idle, so a move mid-command is not seen
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         addr <= SASI_DEFAULT_ADDR;
         sector_large <= 1'b0;
         sector_bytes_out <= SASI_SECT_SMALL;
         sectors_per_track_out <= SASI_SPT_SMALL;
      end else if (phase == SASI_IDLE) begin
         addr <= strap_s1[2:0];
         sector_large <= strap_s1[3];
         sector_bytes_out <= sector_large ? SASI_SECT_LARGE : SASI_SECT_SMALL;
         sectors_per_track_out <= sector_large ? SASI_SPT_LARGE : SASI_SPT_SMALL;
      end
   end

   // Handshake stage: request, wait acknowledge, wait release
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hs <= SASI_HS_SET;
      end else if (bus_rst || bus_quiet(phase)) begin
         hs <= SASI_HS_SET;
      end else begin
         case (hs)
            SASI_HS_SET: hs <= SASI_HS_WAIT;
            SASI_HS_WAIT: if (ack_act) begin
               hs <= SASI_HS_DROP;
            end
            SASI_HS_DROP: if (!ack_act) begin
               hs <= SASI_HS_SET;
            end
            default: hs <= SASI_HS_SET;
         endcase
      end
   end
   // Byte finishes when acknowledge is released, so no byte counts twice
   assign byte_done = (hs == SASI_HS_DROP) && !ack_act;

   always_comb begin
      next_phase = phase;
      case (phase)
         SASI_IDLE: if (sel_act && db_s2[addr] == SASI_ACTIVE_N) begin
            next_phase = SASI_CMD;
         end
         SASI_CMD: if (byte_done && count == 10'(SASI_CMD_BYTES - 4'h1)) begin
            next_phase = !has_data_in ? SASI_STAT : (dir_to_host_in ? SASI_DOUT : SASI_DIN);
         end
         SASI_DIN, SASI_DOUT: if (byte_done && count == data_len_in - 10'h001) begin
            next_phase = SASI_STAT;
         end
         SASI_STAT: if (byte_done) begin
            next_phase = SASI_MSG;
         end
         SASI_MSG: if (byte_done) begin
            next_phase = SASI_REL;
         end
         SASI_REL: if (!sel_act) begin
            next_phase = SASI_IDLE;
         end
         default: next_phase = SASI_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase <= SASI_IDLE;
      end else if (bus_rst) begin
         phase <= SASI_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // Byte counter within a phase
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count <= 10'h000;
      end else if (bus_rst || next_phase != phase) begin
         count <= 10'h000;
      end else if (byte_done) begin
         count <= count + 10'h001;
      end
   end

   assign drv = (phase == SASI_DOUT || phase == SASI_STAT || phase == SASI_MSG);
   always_comb begin
      case (phase)
         SASI_STAT: out_byte = status_in;
         SASI_MSG: out_byte = SASI_MSG_DONE;
         default: out_byte = tx_byte_in;
      endcase
   end

   // Bus outputs, all inactive on reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus.bsy_n <= SASI_INACTIVE_N;
         bus.req_n <= SASI_INACTIVE_N;
         bus.io_n <= SASI_IO_TO_DEV;
         bus.cd_n <= SASI_CD_DATA;
         bus.msg_n <= SASI_INACTIVE_N;
         bus.tgt_db_n <= 8'hFF;
         bus.tgt_db_oe_n <= 1'b1;
         busy_out <= 1'b0;
      end else if (bus_rst || bus_quiet(phase)) begin
         bus.bsy_n <= SASI_INACTIVE_N;
         bus.req_n <= SASI_INACTIVE_N;
         bus.io_n <= SASI_IO_TO_DEV;
         bus.cd_n <= SASI_CD_DATA;
         bus.msg_n <= SASI_INACTIVE_N;
         bus.tgt_db_n <= 8'hFF;
         bus.tgt_db_oe_n <= 1'b1;
         busy_out <= 1'b0;
      end else begin
         bus.bsy_n <= SASI_ACTIVE_N;
         busy_out <= 1'b1;
         // Phase lines settle one cycle before request goes active
         bus.req_n <= (hs == SASI_HS_WAIT) ? SASI_ACTIVE_N : SASI_INACTIVE_N;
         bus.io_n <= drv ? SASI_IO_TO_HOST : SASI_IO_TO_DEV;
         bus.cd_n <= (phase == SASI_DIN || phase == SASI_DOUT) ? SASI_CD_DATA : SASI_CD_COMMAND;
         bus.msg_n <= (phase == SASI_MSG) ? SASI_ACTIVE_N : SASI_INACTIVE_N;
         bus.tgt_db_oe_n <= !drv;
         bus.tgt_db_n <= ~out_byte;
      end
   end

   // Core-side strobes
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_byte_out <= 8'h00;
         cmd_valid_out <= 1'b0;
         cmd_done_out <= 1'b0;
         rx_byte_out <= 8'h00;
         rx_valid_out <= 1'b0;
         tx_take_out <= 1'b0;
      end else begin
         cmd_valid_out <= 1'b0;
         rx_valid_out <= 1'b0;
         tx_take_out <= 1'b0;
         cmd_done_out <= 1'b0;
         if (!bus_rst && hs == SASI_HS_WAIT && ack_act) begin
            if (phase == SASI_CMD) begin
               cmd_byte_out <= ~db_s2;
               cmd_valid_out <= 1'b1;
               cmd_done_out <= (count == 10'(SASI_CMD_BYTES - 4'h1));
            end else if (phase == SASI_DIN) begin
               rx_byte_out <= ~db_s2;
               rx_valid_out <= 1'b1;
            end else if (phase == SASI_DOUT) begin
               tx_take_out <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** hdl/sasi_host.sv ***
// SASI host adapter end: selection, handshake and data bus turnaround
`timescale 1ns/10ps
`default_nettype none
module sasi_host
   import sasi_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Bus
   sasi_if.host bus,
   // User side
   input wire logic start_in,
   input wire logic [2:0] target_in,
   input wire logic bus_reset_in,
   input wire logic [7:0] out_byte_in,
   output logic out_take_out,
   output logic [7:0] in_byte_out,
   output logic in_valid_out,
   output logic in_is_status_out,
   output logic in_is_msg_out,
   output logic idle_out
);
   logic [4:0] s1, s2;
   logic [7:0] d1, d2;
   logic selecting;
   logic req_act, bsy_act, io_dev;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1 <= 5'h1F;
         s2 <= 5'h1F;
         d1 <= 8'hFF;
         d2 <= 8'hFF;
      end else begin
         s1 <= {bus.bsy_n, bus.req_n, bus.io_n, bus.cd_n, bus.msg_n};
         s2 <= s1;
         d1 <= bus.db_n;
         d2 <= d1;
      end
   end
   assign bsy_act = (s2[4] == SASI_ACTIVE_N);
   assign req_act = (s2[3] == SASI_ACTIVE_N);
   assign io_dev = (s2[2] == SASI_IO_TO_DEV);

   // Selection only while busy inactive
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         selecting <= 1'b0;
      end else if (bus_reset_in || bsy_act) begin
         selecting <= 1'b0;
      end else if (start_in) begin
         selecting <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus.sel_n <= SASI_INACTIVE_N;
         bus.ack_n <= SASI_INACTIVE_N;
         bus.rst_n <= SASI_INACTIVE_N;
         bus.host_db_n <= 8'hFF;
         bus.host_db_oe_n <= 1'b1;
         out_take_out <= 1'b0;
         in_byte_out <= 8'h00;
         in_valid_out <= 1'b0;
         in_is_status_out <= 1'b0;
         in_is_msg_out <= 1'b0;
         idle_out <= 1'b1;
      end else begin
         bus.rst_n <= bus_reset_in ? SASI_ACTIVE_N : SASI_INACTIVE_N;
         bus.sel_n <= (selecting && !bus_reset_in) ? SASI_ACTIVE_N : SASI_INACTIVE_N;
         out_take_out <= 1'b0;
         in_valid_out <= 1'b0;
         idle_out <= !bsy_act && !selecting;
         if (selecting) begin
            bus.host_db_n <= ~(8'h01 << target_in);
            bus.host_db_oe_n <= 1'b0;
         end else if (req_act && io_dev && bus.ack_n) begin
            bus.host_db_n <= ~out_byte_in;
            bus.host_db_oe_n <= 1'b0;
         end else if (!io_dev || !bsy_act || (!req_act && bus.ack_n == SASI_ACTIVE_N)) begin
            // Off as each byte ends, so a turn of direction never meets our drivers
            bus.host_db_oe_n <= 1'b1;
         end
         // Data and acknowledge leave on one edge; the target syncs both alike
         if (req_act && bus.ack_n == SASI_INACTIVE_N && bsy_act) begin
            bus.ack_n <= SASI_ACTIVE_N;
            if (io_dev) begin
               out_take_out <= 1'b1;
            end else begin
               in_byte_out <= ~d2;
               in_valid_out <= 1'b1;
               in_is_msg_out <= (s2[0] == SASI_ACTIVE_N);
               in_is_status_out <= (s2[0] != SASI_ACTIVE_N) && (s2[1] == SASI_CD_COMMAND);
            end
         end else if (!req_act) begin
            bus.ack_n <= SASI_INACTIVE_N;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/sasi_sva.sv ***
// Bus protocol checker for the SASI target and host ends
`timescale 1ns/10ps
`default_nettype none
module sasi_sva
   import sasi_pkg::*;
(
   // Clock, reset and strap
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] addr_strap_in,
   // Bus signals
   input wire logic [7:0] db_n,
   input wire logic tgt_db_oe_n,
   input wire logic host_db_oe_n,
   input wire logic bsy_n,
   input wire logic req_n,
   input wire logic io_n,
   input wire logic cd_n,
   input wire logic msg_n,
   input wire logic sel_n,
   input wire logic ack_n,
   input wire logic rst_n
);
   default clocking @(posedge clk_in);
   endclocking
   // Bus reset legally drops everything at once
   default disable iff (!nrst_in || !rst_n);
   logic [3:0] n_req;
   // Requests seen since busy went active
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         n_req <= 4'h0;
      end else if (bsy_n) begin
         n_req <= 4'h0;
      end else if ($fell(req_n) && n_req != 4'hF) begin
         n_req <= n_req + 4'h1;
      end
   end
   a_msg_dir_low: assert property (!msg_n |-> !io_n)
      else $error("message active while direction high");
   a_tgt_drive_dir: assert property (!tgt_db_oe_n |-> !io_n)
      else $error("target drives data with direction high");
   a_host_drive_dir: assert property (!host_db_oe_n |-> io_n)
      else $error("host drives data with direction low");
   a_busy_answer: assert property ($fell(sel_n) && bsy_n && !db_n[addr_strap_in] |-> ##[1:8] !bsy_n)
      else $error("busy not answered to own selection");
   a_foreign_quiet: assert property ((!sel_n && db_n[addr_strap_in]) [*6] |-> bsy_n)
      else $error("busy answered to foreign selection");
   a_req_stands: assert property (!req_n && ack_n |=> !req_n)
      else $error("request dropped before acknowledge");
   a_cmd_first: assert property ($fell(req_n) && n_req < SASI_CMD_BYTES |-> !cd_n && io_n && !bsy_n)
      else $error("first bytes not in command phase");
   a_msg_byte: assert property (!req_n && !msg_n |-> !tgt_db_oe_n && db_n == ~SASI_MSG_DONE)
      else $error("message byte not driven as completion");
   a_busy_hold: assert property (!bsy_n && msg_n |=> !bsy_n)
      else $error("busy released before message phase");
   a_req_in_busy: assert property (!req_n |-> !bsy_n)
      else $error("request outside a transaction");
   a_sel_free: assert property ($fell(sel_n) |-> bsy_n)
      else $error("selection started while busy active");
   a_sel_addr: assert property (!sel_n |-> !host_db_oe_n)
      else $error("selection without address on the data bus");
endmodule
`default_nettype wire

// *** tb/test_sasi_target_bus_phase_logic.sv ***
// Testbench joining the SASI host adapter end to the target port
`timescale 1ns/10ps
`default_nettype none
module test_sasi_target_bus_phase_logic;
   import sasi_pkg::*;
   logic clk_in = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] addr_strap = 3'h0;
   logic sect_strap = 1'b0;
   logic dir_to_host = 1'b0;
   logic has_data = 1'b0;
   logic [9:0] data_len = 10'h000;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] status = 8'h00;
   logic start = 1'b0;
   logic [2:0] tgt = 3'h0;
   logic bus_reset = 1'b0;
   logic [7:0] out_byte = 8'h00;
   logic [7:0] cmd_byte, rx_byte, in_byte;
   logic cmd_valid, cmd_done, rx_valid, tx_take, busy, out_take, in_valid, in_stat, in_msg, idle;
   logic [9:0] sect_bytes;
   logic [5:0] spt;
   logic [7:0] out_q[$];
   logic [7:0] tx_q[$];
   logic [7:0] got_cmd[$];
   logic [7:0] got_rx[$];
   logic [9:0] got_in[$];
   int oi, ti, n_done;
   int n_fail = 0;
   int tests_run = 0;
   always #5 clk_in = ~clk_in;
   sasi_if bus_if ();
   sasi_target sasi_target_inst (.clk_in(clk_in), .nrst_in(nrst), .bus(bus_if), .addr_strap_in(addr_strap),
      .sector_size_strap_in(sect_strap), .cmd_byte_out(cmd_byte), .cmd_valid_out(cmd_valid),
      .cmd_done_out(cmd_done), .dir_to_host_in(dir_to_host), .has_data_in(has_data), .data_len_in(data_len),
      .tx_byte_in(tx_byte), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .tx_take_out(tx_take),
      .status_in(status), .sector_bytes_out(sect_bytes), .sectors_per_track_out(spt), .busy_out(busy));
   sasi_host sasi_host_inst (.clk_in(clk_in), .nrst_in(nrst), .bus(bus_if), .start_in(start), .target_in(tgt),
      .bus_reset_in(bus_reset), .out_byte_in(out_byte), .out_take_out(out_take), .in_byte_out(in_byte),
      .in_valid_out(in_valid), .in_is_status_out(in_stat), .in_is_msg_out(in_msg), .idle_out(idle));
   sasi_sva sasi_sva_inst (.clk_in(clk_in), .nrst_in(nrst), .addr_strap_in(addr_strap), .db_n(bus_if.db_n),
      .tgt_db_oe_n(bus_if.tgt_db_oe_n), .host_db_oe_n(bus_if.host_db_oe_n), .bsy_n(bus_if.bsy_n),
      .req_n(bus_if.req_n), .io_n(bus_if.io_n), .cd_n(bus_if.cd_n), .msg_n(bus_if.msg_n),
      .sel_n(bus_if.sel_n), .ack_n(bus_if.ack_n), .rst_n(bus_if.rst_n));
   // Both user sides: collect pulses, feed next byte just after the edge
   always @(posedge clk_in) begin
      if (cmd_valid) got_cmd.push_back(cmd_byte);
      if (cmd_done) n_done++;
      if (rx_valid) got_rx.push_back(rx_byte);
      if (in_valid) got_in.push_back({in_msg, in_stat, in_byte});
      if (out_take) oi++;
      if (tx_take) ti++;
      #1;
      out_byte = (oi < out_q.size()) ? out_q[oi] : 8'h00;
      tx_byte = (ti < tx_q.size()) ? tx_q[ti] : 8'h00;
   end
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask
   task automatic conclude();
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic reset_all();
      nrst = 1'b0;
      repeat (6) tick();
      nrst = 1'b1;
      tick();
   endtask
   task automatic launch(input logic [2:0] adr, input logic [2:0] to, input logic dh, input logic hd, input int len,
      input logic [7:0] st);
      int k;
      {oi, ti, n_done} = '0;
      out_q.delete();
      tx_q.delete();
      got_cmd.delete();
      got_rx.delete();
      got_in.delete();
      {addr_strap, tgt, dir_to_host, has_data, data_len, status} = {adr, to, dh, hd, len[9:0], st};
      for (k = 0; k < 6; k++) out_q.push_back({k[3:0], 1'b0, to});
      for (k = 0; k < len && hd; k++) begin
         if (dh) tx_q.push_back({4'h5, k[3:0]});
         else out_q.push_back({4'hC, k[3:0]});
      end
      repeat (2) tick();
      start = 1'b1;
      tick();
      start = 1'b0;
   endtask
   task automatic run_cmd(input logic [2:0] adr, input logic dh, input logic hd, input int len, input logic [7:0] st);
      int k;
      int nin;
      launch(adr, adr, dh, hd, len, st);
      for (k = 0; k < 3000 && !(got_in.size() > 0 && got_in[$][9]); k++) tick();
      for (k = 0; k < 30 && (busy || !idle); k++) tick();
      nin = (hd && dh) ? len : 0;
      check(busy, 1'b0);
      check(idle, 1'b1);
      check(n_done, 1);
      for (k = 0; k < 6; k++) check(got_cmd[k], out_q[k]);
      check(got_rx.size(), (hd && !dh) ? len : 0);
      for (k = 0; k < got_rx.size(); k++) check(got_rx[k], out_q[6 + k]);
      check(got_in.size(), nin + 2);
      for (k = 0; k < nin; k++) check(got_in[k], {2'b00, tx_q[k]});
      check(got_in[nin], {2'b01, st});
      check(got_in[nin + 1], {2'b10, SASI_MSG_DONE});
   endtask
   initial begin
      int a;
      reset_all();
      for (a = 0; a < 2; a++) begin
         sect_strap = a[0];
         repeat (3) tick();
         check(sect_bytes, a[0] ? SASI_SECT_LARGE : SASI_SECT_SMALL);
         check(spt, a[0] ? SASI_SPT_LARGE : SASI_SPT_SMALL);
      end
      $display("sector strap test done");
      run_cmd(SASI_DEFAULT_ADDR, 1'b0, 1'b0, 0, 8'h00);
      $display("default address test done");
      // Each address, alternating direction, growing length
      for (a = 0; a < 8; a++) run_cmd(a[2:0], a[0], 1'b1, a + 1, 8'h02 + a[7:0]);
      $display("address sweep test done");
      launch(3'h2, 3'h6, 1'b0, 1'b0, 0, 8'h00);
      repeat (30) tick();
      check(bus_if.bsy_n, 1'b1);
      check(busy, 1'b0);
      reset_all();
      $display("foreign select test done");
      launch(3'h1, 3'h1, 1'b0, 1'b1, 8, 8'h00);
      for (a = 0; a < 500 && got_cmd.size() < 3; a++) tick();
      bus_reset = 1'b1;
      repeat (10) tick();
      check(busy, 1'b0);
      check(bus_if.bsy_n, 1'b1);
      check(bus_if.req_n, 1'b1);
      bus_reset = 1'b0;
      reset_all();
      run_cmd(3'h1, 1'b1, 1'b1, 16, 8'h30);
      $display("bus reset test done");
      conclude();
   end
   initial begin
      repeat (60000) @(posedge clk_in);
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
